/* common/prw_consts.svh */
`ifndef PRW_CONSTS_SVH
`define PRW_CONSTS_SVH
`define PRW_CNT_W     16
`define PRW_CNT_INIT  16'hffff
`define PRW_CNT_ZERO  16'h0000
`define PRW_CNT_ONE   16'h0001
`define PRW_SYNC_CLR  3'h0
`endif

/* common/prw_pkg.sv */
package prw_pkg;
  // strobes from the instruction decoder, one per instruction cycle
  typedef struct packed {
    logic cycle;
    logic kick;
    logic disPrep;
    logic powerDown;
    logic ramBackup;
  } prw_strobe_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        enable;
    logic        flag1;
    logic        flag2;
    logic        disPending;
    logic        skip;
    logic        wdReset;
    logic        pinLow;
    logic [2:0]  pinSync;
  } prw_state_t;
endpackage : prw_pkg

/* core/prw_watchdog.sv */
`timescale 1ns/1ps
`include "prw_consts.svh"
module prw_watchdog
  import prw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // decoder strobes, same clock
  input  wire prw_strobe_t strobe,
  // reset pin, sensed level comes from outside the domain
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  // status towards the core
  output logic             skip,
  output logic             firstUnderflowFlag,
  output logic             secondUnderflowFlag,
  output logic             supervisionEnableFlag,
  output logic             resetPinLow
);

  prw_state_t st;
  prw_state_t next_st;
  logic       underflow;

  // ==========================================================
  // decode shared by the next-state logic and the checks
  function automatic logic cnt_at_zero(input logic [`PRW_CNT_W-1:0] c);
    return (c == `PRW_CNT_ZERO);
  endfunction : cnt_at_zero

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    underflow = 1'b0;
    next_st.skip = 1'b0;
    next_st.pinSync = {st.pinSync[1:0], resetPinIn};
    // registered so the status pin comes straight from a flop
    next_st.pinLow = ~st.pinSync[2] & ~st.pinSync[1] & st.wdReset;
    if (strobe.cycle)
    begin
      underflow = cnt_at_zero(st.cnt);
      next_st.cnt = st.cnt - `PRW_CNT_ONE;
      // pending disable lives one instruction cycle only
      next_st.disPending = strobe.disPrep;
      if (underflow)
      begin
        if (st.flag1 && st.enable)
        begin
          next_st.flag2 = 1'b1;
          next_st.wdReset = 1'b1;
        end
        next_st.flag1 = 1'b1;
      end
      if (strobe.kick)
      begin
        // skip test is independent of the enable flag
        next_st.skip = st.flag1;
        next_st.flag1 = 1'b0;
        if (st.disPending)
          next_st.enable = 1'b0;
      end
    end
    if (strobe.powerDown)
    begin
      next_st.cnt = `PRW_CNT_INIT;
      next_st.flag1 = 1'b0;
      next_st.enable = 1'b1;
      next_st.disPending = 1'b0;
    end
    if (strobe.ramBackup)
      next_st.enable = 1'b1;
  end

  // ==========================================================
  // state register; system reset reloads everything
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st.cnt        <= `PRW_CNT_INIT;
      st.enable     <= 1'b1;
      st.flag1      <= 1'b0;
      st.flag2      <= 1'b0;
      st.disPending <= 1'b0;
      st.skip       <= 1'b0;
      st.wdReset    <= 1'b0;
      st.pinSync    <= `PRW_SYNC_CLR;
      st.pinLow     <= 1'b0;
    end
    else
      st <= next_st;
  end

  // pull-down only, pin released otherwise; held until system reset
  assign resetPinOut           = 1'b0;
  assign resetPinOe            = st.wdReset;
  assign skip                  = st.skip;
  assign firstUnderflowFlag    = st.flag1;
  assign secondUnderflowFlag   = st.flag2;
  assign supervisionEnableFlag = st.enable;

  // ==========================================================
  // pin sense
  // filtered pin level while the watchdog drives reset: stages two and three agree on low;
  // costs one extra cycle of latency, traded for a clean output
  assign resetPinLow = st.pinLow;

  // ==========================================================
  // checks
  a_underflow_sets_flag1:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && !strobe.powerDown && !strobe.kick
      && cnt_at_zero(st.cnt)
      |=> st.flag1 && st.cnt == `PRW_CNT_INIT)
    else $error("underflow did not set first flag");

  a_second_underflow_reset:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && cnt_at_zero(st.cnt) && st.flag1 && st.enable
      |=> st.flag2 && resetPinOe)
    else $error("second underflow did not assert reset");

  a_disabled_no_reset:
    assert property (@(posedge clk) disable iff (rst)
      !st.enable && !st.wdReset |=> !resetPinOe)
    else $error("reset asserted while disabled");

  a_kick_skip_value:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && strobe.kick |=> skip == $past(st.flag1))
    else $error("kick skip mismatch");

  a_kick_clears_flag1:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && strobe.kick && !cnt_at_zero(st.cnt)
      |=> !st.flag1)
    else $error("kick did not clear first flag");

  a_disable_pair:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && strobe.kick && st.disPending
      && !strobe.powerDown && !strobe.ramBackup |=> !st.enable)
    else $error("disable pair did not clear enable");

  a_prep_alone_keeps:
    assert property (@(posedge clk) disable iff (rst)
      st.enable && !(strobe.kick && st.disPending) |=> st.enable)
    else $error("enable dropped without disable pair");

  a_power_down_init:
    assert property (@(posedge clk) disable iff (rst)
      strobe.powerDown |=> st.cnt == `PRW_CNT_INIT && !st.flag1
      && st.enable)
    else $error("power-down did not re-initialise");

  a_count_decrement:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && !strobe.powerDown
      |=> st.cnt == $past(st.cnt) - `PRW_CNT_ONE)
    else $error("counter did not decrement");

  // skip is a one-cycle answer to a kick, never spontaneous
  a_no_kick_no_skip:
    assert property (@(posedge clk) disable iff (rst)
      !(strobe.cycle && strobe.kick) |=> !skip)
    else $error("skip without kick");

  a_pin_low_sense:
    assert property (@(posedge clk) disable iff (rst)
      st.wdReset && !st.pinSync[2] && !st.pinSync[1] |=> resetPinLow)
    else $error("pin low not reported");

  a_pin_low_drive:
    assert property (@(posedge clk) disable iff (rst)
      resetPinLow |-> resetPinOe && !resetPinOut)
    else $error("pin low reported without drive");

  a_ram_backup_enable:
    assert property (@(posedge clk) disable iff (rst)
      strobe.ramBackup |=> st.enable)
    else $error("RAM back-up did not set enable");

  a_disabled_keeps_flag2:
    assert property (@(posedge clk) disable iff (rst)
      !st.enable && !st.flag2 |=> !st.flag2)
    else $error("second flag set while disabled");

  // only an external system reset may clear the watchdog reset
  a_flag2_sticky:
    assert property (@(posedge clk) disable iff (rst)
      st.flag2 |=> st.flag2 && resetPinOe)
    else $error("second flag or reset dropped");

  a_pend_one_cycle:
    assert property (@(posedge clk) disable iff (rst)
      strobe.cycle && !strobe.disPrep |=> !st.disPending)
    else $error("pending disable outlived a cycle");

  a_kick_no_cycle:
    assert property (@(posedge clk) disable iff (rst)
      !strobe.cycle && !strobe.powerDown && !strobe.ramBackup
      |=> st.enable == $past(st.enable))
    else $error("enable moved without instruction cycle");

endmodule : prw_watchdog

/* dv/program_runaway_watchdog_bench.sv */
`timescale 1ns/1ps
// ==========
// bench
module program_runaway_watchdog_bench
  import prw_pkg::*;
;
  logic clk, rst, pd, rb, skip, f1, f2, en, oe, low;
  logic [1:0] op;
  logic exEn, prev;
  prw_strobe_t strobe;
  int n_mismatch = 0;
  int checks = 0;
  prw_decoder_model u_dec (.op(op), .powerDown(pd), .ramBackup(rb),
    .strobe(strobe));
  // pull-up on the reset pin, pulled low while resetPinOe is driven
  prw_watchdog u_dut (.clk(clk), .rst(rst), .strobe(strobe),
    .resetPinIn(~oe), .resetPinOut(), .resetPinOe(oe), .skip(skip),
    .firstUnderflowFlag(f1), .secondUnderflowFlag(f2),
    .supervisionEnableFlag(en), .resetPinLow(low));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task tally_and_finish;
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t flag mismatch", $time);
    end
  endtask : chk
  task put(input logic [1:0] o);
    @(posedge clk);
    op <= o;
  endtask : put
  task kick(input logic exp);
    put(2'h1);
    put(2'h0);
    @(negedge clk);
    chk(skip, exp);
  endtask : kick
  task run(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : run
  function logic nextEn(input logic e, input logic p, input logic [1:0] o);
    return (p && o == 2'h1) ? 1'b0 : e;
  endfunction : nextEn
  initial
  begin
    #(140000 * 25);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'he3c7));
    {rst, pd, rb, op} = {3'h4, 2'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(en, 1'b1);
    chk(f1 | f2 | oe, 1'b0);
    kick(1'b0);
    run(65520);
    chk(f1, 1'b0);
    run(20);
    chk(f1, 1'b1);
    run(65516);
    chk(f2, 1'b0);
    run(20);
    chk(f2 & oe, 1'b1);
    chk(low, 1'b1);
    kick(1'b1);
    chk(f1, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    run(2);
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(f2 | oe, 1'b0);
    chk(en, 1'b1);
    put(2'h2);
    put(2'h0);
    kick(1'b0);
    chk(en, 1'b1);
    put(2'h2);
    kick(1'b0);
    chk(en, 1'b0);
    @(posedge clk);
    rb <= 1'b1;
    @(posedge clk);
    rb <= 1'b0;
    @(negedge clk);
    chk(en, 1'b1);
    put(2'h2);
    kick(1'b0);
    chk(en, 1'b0);
    // kick just before power-down, as software should
    kick(1'b0);
    @(posedge clk);
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    run(1);
    chk(en, 1'b1);
    chk(f1, 1'b0);
    {exEn, prev} = 2'h2;
    @(posedge clk);
    repeat (200)
    begin
      op <= 2'($urandom % 3);
      @(posedge clk);
      exEn = nextEn(exEn, prev, op);
      prev = op == 2'h2;
    end
    op <= 2'h0;
    run(1);
    chk(en, exEn);
    tally_and_finish();
  end
endmodule : program_runaway_watchdog_bench

/* dv/prw_decoder_model.sv */
`timescale 1ns/1ps
// ==========
// decoder model: one instruction every clock
module prw_decoder_model
  import prw_pkg::*;
(
  // 0 other, 1 kick, 2 disable-prepare
  input  wire logic [1:0] op,
  input  wire logic       powerDown,
  input  wire logic       ramBackup,
  // strobes to the watchdog
  output prw_strobe_t     strobe
);
  assign strobe = '{cycle: 1'b1, kick: op == 2'h1, disPrep: op == 2'h2,
                    powerDown: powerDown, ramBackup: ramBackup};
endmodule : prw_decoder_model
